// [porst_pkg.sv]
// package for the power-on reset timer: constants, modes, state carriers
`default_nettype none
package porst_pkg;
    // oscillator mode encodings of the two select bits
    typedef enum logic [1:0] {
        low_power_crystal_mode = 2'h0,
        crystal_resonator_mode = 2'h1,
        high_speed_crystal_mode = 2'h2,
        resistor_capacitor_osc_mode = 2'h3
    } porst_osc_mode_t;

    // clock and delay timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_DELAY_PERIOD_MS = 18;
    localparam int RESET_DELAY_CYCLES = (RESET_DELAY_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 20'h0_0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // sequencer states, gray along the path
    typedef enum logic [1:0] {
        porst_hold = 2'b00,
        porst_count = 2'b01,
        porst_run = 2'b11
    } porst_state_t;

    // oscillator configuration outputs
    typedef struct packed {
        logic ext_clock_allowed;
        logic crystal_drive_en;
        logic rc_osc_en;
        porst_osc_mode_t mode;
    } porst_osc_cfg_t;

    typedef struct packed {
        porst_state_t state;
        logic [TIMER_W-1:0] timer;
        logic chip_reset;
    } porst_seq_t;

    typedef struct packed {
        logic [1:0] sync;
    } porst_sync_t;

    // true for any of the three crystal modes
    function automatic logic porst_is_crystal(input porst_osc_mode_t m);
        return m != resistor_capacitor_osc_mode;
    endfunction
endpackage
`default_nettype wire

// [porst_sync.sv]
// two-flop synchroniser for the master clear pin
`default_nettype none
module porst_sync
    import porst_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    porst_sync_t st;
    porst_sync_t next_st;

    // shift the pin level through two stages
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[0], din};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st.sync <= SYNC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.sync[1];
endmodule // porst_sync
`default_nettype wire

// [porst_timer.sv]
// power-on reset latch, reset-delay timer and oscillator mode decode
`default_nettype none
module porst_timer
    import porst_pkg::*;
#(
    parameter int DELAY_CYCLES = RESET_DELAY_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic master_clear_n,
    input wire logic [1:0] osc_select_bits,
    output logic chip_reset,
    output logic ext_clock_allowed,
    output logic crystal_drive_en,
    output logic rc_osc_en,
    output logic [1:0] osc_mode
);
    localparam logic [TIMER_W-1:0] LAST = TIMER_W'(DELAY_CYCLES - 1);

    logic master_clear_n_high;
    porst_seq_t seq;
    porst_seq_t next_seq;
    porst_osc_cfg_t cfg;
    porst_osc_cfg_t next_cfg;

    // pin passes two flops before any logic reads it
    porst_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(master_clear_n),
        .dout(master_clear_n_high)
    );

    // reset latch and delay timer sequencing
    always_comb begin
        next_seq = seq;
        unique case (seq.state)
            porst_hold: begin
                next_seq.timer = TIMER_RESET;
                next_seq.chip_reset = 1'b1;
                if (master_clear_n_high) begin
                    next_seq.state = porst_count;
                end
            end
            porst_count: begin
                if (!master_clear_n_high) begin
                    next_seq.state = porst_hold;
                    next_seq.timer = TIMER_RESET;
                end else if (seq.timer == LAST) begin
                    next_seq.state = porst_run;
                    next_seq.chip_reset = 1'b0;
                end else begin
                    next_seq.timer = seq.timer + 1'b1;
                end
            end
            porst_run: begin
                // latch stays clear; the power-up reset or a low master clear pin re-arms it
                next_seq.chip_reset = 1'b0;
                if (!master_clear_n_high) begin // pin reset re-arms the delay
                    next_seq.state = porst_hold;
                    next_seq.chip_reset = 1'b1;
                    next_seq.timer = TIMER_RESET;
                end
            end
            default: begin
                next_seq.state = porst_hold;
                next_seq.chip_reset = 1'b1;
                next_seq.timer = TIMER_RESET;
            end
        endcase
    end

    // oscillator mode decode, registered
    always_comb begin
        next_cfg.mode = porst_osc_mode_t'(osc_select_bits);
        next_cfg.ext_clock_allowed = porst_is_crystal(next_cfg.mode);
        next_cfg.crystal_drive_en = porst_is_crystal(next_cfg.mode);
        next_cfg.rc_osc_en = !porst_is_crystal(next_cfg.mode);
    end

    // power-up sets the latch and clears the timer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq.state <= porst_hold;
            seq.timer <= TIMER_RESET;
            seq.chip_reset <= 1'b1;
            cfg.mode <= low_power_crystal_mode;
            cfg.ext_clock_allowed <= 1'b1;
            cfg.crystal_drive_en <= 1'b1;
            cfg.rc_osc_en <= 1'b0;
        end else begin
            seq <= next_seq;
            cfg <= next_cfg;
        end
    end

    assign chip_reset = seq.chip_reset;
    assign ext_clock_allowed = cfg.ext_clock_allowed;
    assign crystal_drive_en = cfg.crystal_drive_en;
    assign rc_osc_en = cfg.rc_osc_en;
    assign osc_mode = cfg.mode;

    // reset held while waiting for master clear
    property p_hold_while_low;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_hold) |-> chip_reset;
    endproperty
    a_hold_while_low: assert property (p_hold_while_low) else $error("reset dropped before count");

    // timer stays clear until master clear high
    property p_timer_idle;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_hold) |-> (seq.timer == TIMER_RESET);
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("timer ran in hold");

    // release exactly on the last count
    property p_release;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_count && master_clear_n_high && seq.timer == LAST) |=> !chip_reset;
    endproperty
    a_release: assert property (p_release) else $error("reset not released at time-out");

    // no early release
    property p_no_early;
        @(posedge mclk) disable iff (!rst_n)
        $fell(chip_reset) |-> ($past(seq.timer) == LAST);
    endproperty
    a_no_early: assert property (p_no_early) else $error("reset released early");

    // low pin during count restarts the delay
    property p_restart;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_count && !master_clear_n_high) |=> (seq.timer == TIMER_RESET && chip_reset);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not cleared on master clear");

    // counting advances by one while high
    property p_count_step;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_count && master_clear_n_high && seq.timer != LAST) |=> (seq.timer == $past(seq.timer) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("timer did not advance");

    // mode output follows select bits one cycle later
    property p_mode;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> (osc_mode == $past(osc_select_bits));
    endproperty
    a_mode: assert property (p_mode) else $error("oscillator mode wrong");

    // external clock allowed only in crystal modes
    property p_ext_clk;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> (ext_clock_allowed == ($past(osc_select_bits) != 2'h3));
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("external clock permission wrong");

    // run state keeps reset clear while pin high
    property p_run_stays;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_run && master_clear_n_high) |=> !chip_reset;
    endproperty
    a_run_stays: assert property (p_run_stays) else $error("spurious reset in run");

    // pin low keeps the sequencer waiting
    property p_wait_for_pin;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_hold && !master_clear_n_high) |=> (seq.state == porst_hold);
    endproperty
    a_wait_for_pin: assert property (p_wait_for_pin) else $error("timer started while pin low");

    // first high sample starts the count from zero
    property p_start_count;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_hold && master_clear_n_high) |=> (seq.state == porst_count && seq.timer == TIMER_RESET);
    endproperty
    a_start_count: assert property (p_start_count) else $error("count did not start from zero");

    // reset stays asserted for the whole count
    property p_held_in_count;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_count) |-> chip_reset;
    endproperty
    a_held_in_count: assert property (p_held_in_count) else $error("reset dropped during count");

    // timer never runs past its last count
    property p_timer_bound;
        @(posedge mclk) disable iff (!rst_n)
        seq.timer <= LAST;
    endproperty
    a_timer_bound: assert property (p_timer_bound) else $error("timer past last count");

    // pin low after release re-arms the latch and clears the timer
    property p_rearm;
        @(posedge mclk) disable iff (!rst_n)
        (seq.state == porst_run && !master_clear_n_high) |=> (chip_reset && seq.timer == TIMER_RESET);
    endproperty
    a_rearm: assert property (p_rearm) else $error("pin low did not re-arm reset");

    // rc oscillator only in the resistor-capacitor mode
    property p_rc_osc;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> (rc_osc_en == ($past(osc_select_bits) == 2'h3));
    endproperty
    a_rc_osc: assert property (p_rc_osc) else $error("rc oscillator enable wrong");

    // crystal driver on in every crystal mode
    property p_crystal_drive;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> (crystal_drive_en == ($past(osc_select_bits) != 2'h3));
    endproperty
    a_crystal_drive: assert property (p_crystal_drive) else $error("crystal drive enable wrong");

    c_release: cover property (@(posedge mclk) disable iff (!rst_n) $fell(chip_reset));
    c_restart: cover property (@(posedge mclk) disable iff (!rst_n) seq.state == porst_count && !master_clear_n_high);
    c_rc_mode: cover property (@(posedge mclk) disable iff (!rst_n) rc_osc_en);
    c_rearm: cover property (@(posedge mclk) disable iff (!rst_n) seq.state == porst_run && !master_clear_n_high);
    c_last_count: cover property (@(posedge mclk) disable iff (!rst_n) seq.state == porst_count && seq.timer == LAST);
endmodule // porst_timer
`default_nettype wire

// [porst_board.sv]
// board reset circuit model driving the master clear pin
`default_nettype none
module porst_board
    import porst_pkg::*;
(
    input wire logic mclk,
    input wire logic supply_ok,
    input wire logic glitch,
    output logic master_clear_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin held low until the supply is good, pulled low again on a commanded glitch
    always_ff @(posedge mclk) begin
        master_clear_n <= supply_ok & ~glitch;
    end
endmodule // porst_board
`default_nettype wire

// [power_on_reset_timer_tb.sv]
// self-checking testbench for the power-on reset timer
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module power_on_reset_timer_tb
    import porst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 10;
    logic mclk, rst_n, supply_ok, glitch, master_clear_n, chip_reset;
    logic ext_clock_allowed, crystal_drive_en, rc_osc_en;
    logic [1:0] osc_select_bits, osc_mode;
    int fail_count = 0;
    int n_compared = 0;
    int n;

    porst_board board (.mclk(mclk), .supply_ok(supply_ok), .glitch(glitch), .master_clear_n(master_clear_n));
    porst_timer #(.DELAY_CYCLES(D)) dut (.mclk(mclk), .rst_n(rst_n), .master_clear_n(master_clear_n),
        .osc_select_bits(osc_select_bits), .chip_reset(chip_reset), .ext_clock_allowed(ext_clock_allowed),
        .crystal_drive_en(crystal_drive_en), .rc_osc_en(rc_osc_en), .osc_mode(osc_mode));

    // expected config outputs: {ext clock, crystal drive, rc osc, mode}
    function automatic logic [4:0] exp_cfg(input logic [1:0] m);
        return {m != 2'h3, m != 2'h3, m == 2'h3, m};
    endfunction

    // edges to release: lead edges to pin rise, two sync stages, one to start, then D counts
    function automatic int exp_release(input int lead);
        return lead + 3 + D;
    endfunction

    // board pulls master clear low for three cycles
    task automatic pulse_pin();
        @(posedge mclk);
        glitch <= 1'b1;
        repeat (3) @(posedge mclk);
        glitch <= 1'b0;
    endtask

    // cycles from now until chip reset drops, bounded
    task automatic measure(output int cnt);
        cnt = 0;
        while (chip_reset === 1'b1 && cnt < 4 * D) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
    endtask

    task automatic check_mode(input logic [1:0] m);
        @(posedge mclk);
        osc_select_bits <= m;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("osc config", exp_cfg(m), {ext_clock_allowed, crystal_drive_en, rc_osc_en, osc_mode})
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // watchdog against a hung sequence
    initial begin
        #(40 * 3000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        supply_ok = 1'b0;
        glitch = 1'b0;
        osc_select_bits = 2'h0;
        void'($urandom(82));
        repeat (19) @(posedge mclk);
        #1;
        `CHK("reset held at power-up", 1'b1, chip_reset)
        @(posedge mclk);
        rst_n <= 1'b1;
        // all four modes, then random ones
        for (int m = 0; m < 4; m++) check_mode(m[1:0]);
        repeat (4) check_mode(2'($urandom % 4));
        // master clear held low: no release
        repeat (3 * D) @(posedge mclk);
        #1;
        `CHK("reset while pin low", 1'b1, chip_reset)
        @(posedge mclk);
        supply_ok <= 1'b1;
        // glitch before time-out restarts the full period
        repeat (3 + $urandom % (D - 3)) @(posedge mclk);
        #1;
        `CHK("reset before time-out", 1'b1, chip_reset)
        pulse_pin();
        measure(n);
        `CHK("full period after glitch", exp_release(1), n)
        repeat (5) @(posedge mclk);
        #1;
        `CHK("reset stays released", 1'b0, chip_reset)
        // pin low after release re-arms the delay
        pulse_pin();
        @(posedge mclk);
        #1;
        `CHK("reset re-armed by pin", 1'b1, chip_reset)
        measure(n);
        `CHK("full period after re-arm", exp_release(0), n)
        // second power-up re-arms the latch
        @(posedge mclk);
        rst_n <= 1'b0;
        #1;
        `CHK("reset on power-up", 1'b1, chip_reset)
        @(posedge mclk);
        rst_n <= 1'b1;
        measure(n);
        `CHK("period after power-up", exp_release(0), n)
        report_and_stop();
    end
endmodule // power_on_reset_timer_tb
`default_nettype wire
